// *** common/uart_int_ctrl_defines.vh ***
`ifndef UART_INT_CTRL_DEFINES_VH
`define UART_INT_CTRL_DEFINES_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_INTERRUPT_MASK  8'h04
`define ADDR_FIFO_CONTROL    8'h08
`define ADDR_INTERRUPT_SRC   8'h08
`define ADDR_LINE_STATUS     8'h14

// ----------------------------------------
// interrupt mask fields
// ----------------------------------------
`define MASK_RX_DATA         0
`define MASK_THR_EMPTY       1
`define MASK_LINE_STATUS     2
`define MASK_MODEM_STATUS    3
`define MASK_POWER_DOWN      5
`define MASK_RESET           8'h00
`define MASK_WRITABLE        8'h2F
`define MASK_NO_PD           8'h0F

// ----------------------------------------
// fifo control fields
// ----------------------------------------
`define FCR_FIFO_EN          0
`define FCR_RX_CLEAR         1
`define FCR_TX_CLEAR         2
`define FCR_DMA_MODE         3
`define FCR_TRIG_LO          6
`define FCR_TRIG_HI          7

// ----------------------------------------
// receive trigger levels and fifo size
// ----------------------------------------
`define TRIG_SEL_1           2'h0
`define TRIG_SEL_4           2'h1
`define TRIG_SEL_8           2'h2
`define TRIG_LEVEL_1         5'h01
`define TRIG_LEVEL_4         5'h04
`define TRIG_LEVEL_8         5'h08
`define TRIG_LEVEL_14        5'h0E
`define FIFO_DEPTH           5'h10
`define FIFO_EMPTY           5'h00

// ----------------------------------------
// interrupt source codes, bits 3:0, and fifo flags, bits 7:6
// ----------------------------------------
`define SRC_NONE             4'h1
`define SRC_LINE_STATUS      4'h6
`define SRC_RX_DATA          4'h4
`define SRC_RX_TIMEOUT       4'hC
`define SRC_THR_EMPTY        4'h2
`define SRC_MODEM_STATUS     4'h0
`define SRC_FIFO_FLAGS       2'h3

// ----------------------------------------
// receive timeout, in character times
// ----------------------------------------
`define TIMEOUT_CHARS        3'h4
`define TIMEOUT_RESET        3'h0

`endif

// *** rtl/rx_timeout.v ***
`timescale 1ns/100ps
`default_nettype none
`include "uart_int_ctrl_defines.vh"

module rx_timeout (
   input  wire       hclk,
   input  wire       hresetn,
   input  wire       arm,
   input  wire       restart,
   input  wire       char_tick,
   output reg        timeout_q
);

   reg  [2:0] count_q;
   reg  [2:0] count_d;
   reg        timeout_d;

   // ----------------------------------------
   // character-time counter
   // ----------------------------------------
   // any push or pop restarts the wait and drops the flag
   always @* begin
      count_d   = count_q;
      timeout_d = timeout_q;
      if (restart || !arm) begin
         count_d   = `TIMEOUT_RESET;
         timeout_d = 1'b0;
      end else if (char_tick && !timeout_q) begin
         count_d = count_q + 3'h1;
         if (count_d == `TIMEOUT_CHARS)
            timeout_d = 1'b1;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q   <= `TIMEOUT_RESET;
         timeout_q <= 1'b0;
      end else begin
         count_q   <= count_d;
         timeout_q <= timeout_d;
      end
   end

endmodule
`default_nettype wire

// *** rtl/uart_int_ctrl.v ***
// Behaviour
// - fifo mode, rx enable set: rx interrupt while fill at or above trigger.
// - source register shows rx data while fill at or above trigger.
// - data ready flag set on first push, cleared when rx fifo empty.
// - all four mask bits clear with fifos on gives polled operation.
// - line status shows tx fifo empty and tx fifo plus shifter empty.
// - mask bit 1 gates the transmitter empty interrupt.
// - mask bit 2 gates the receiver line status interrupt.
// - mask bit 3 gates the modem status change interrupt.
// - unused mask and fifo control bits read zero; mask resets to zero.
// - power down needs mask bit 5 and modem control bit 7.
// - fifo control bit 0 enables fifos; other bits need bit 0 set.
// - fifo control bit 1 clears the rx fifo, self-clearing.
// - fifo control bit 2 clears the tx fifo, self-clearing.
// - fifo control bit 3 selects dma mode 0 or 1.
// - mode 0: tx ready pin low while no tx character held.
// - mode 0: rx ready pin low while any rx character held.
// - mode 1: tx ready pin high only when tx fifo full.
// - mode 1: rx ready low on trigger or timeout, high once empty.
// - mode 1: tx interrupt while tx fill below trigger.
// - bits 7:6 choose trigger 1, 4, 8 or 14 characters.
// - source read reports and clears only the highest pending source; here a read does not clear rx data or timeout.
// - source codes 0110, 0100, 1100, 0010, 0000 by priority.
// - source bit 0 is zero while pending, one when idle.
// - source bits 7:6 read one with fifos on, zero otherwise.
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "uart_int_ctrl_defines.vh"

module uart_int_ctrl #(
   parameter HAS_POWER_DOWN = 1
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire [4:0]  rx_count,
   input  wire [4:0]  tx_count,
   input  wire        rx_push,
   input  wire        rx_pop,
   input  wire        tx_shift_empty,
   input  wire [3:0]  rx_error_bits,
   input  wire        fifo_data_error,
   input  wire        line_event,
   input  wire        modem_event,
   input  wire        modem_pd_bit,
   input  wire        char_tick,
   output wire        irq,
   output reg         tx_ready_n_pin,
   output reg         rx_ready_n_pin,
   output reg         rx_fifo_clear,
   output reg         tx_fifo_clear,
   output wire        fifo_enable,
   output wire        dma_mode,
   output wire        power_down,
   output wire [7:0]  line_status_reg
);

   // ----------------------------------------
   // declarations
   // ----------------------------------------
   reg  [7:0] interrupt_mask_q;
   reg        fifo_en_q;
   reg        dma_mode_q;
   reg  [1:0] trig_sel_q;
   reg        wr_pend_q;
   reg  [7:0] wr_addr_q;
   reg        ls_pend_q;
   reg        thre_pend_q;
   reg        thre_cond_q;
   reg        ms_pend_q;
   reg        rx_latch_q;
   reg  [4:0] trig_level;
   reg  [3:0] src_code;
   reg  [7:0] rd_value;
   wire       access;
   wire       rd_access;
   wire       isr_read;
   wire       wr_mask;
   wire       wr_fifo;
   wire       rx_timeout_q;
   wire       rx_at_trig;
   wire       thre_cond;
   wire       rx_empty;
   wire       tx_empty;
   wire       en_rx;
   wire       en_thre;
   wire       en_ls;
   wire       en_ms;
   wire       rx_data_int;
   wire       timeout_int;
   wire [7:0] mask_keep;

   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   // zero wait states: every transfer completes with okay
   // hsize is ignored: a narrow write updates the whole byte
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign access    = hsel && htrans[1] && hready;
   assign rd_access = access && !hwrite;
   assign isr_read  = rd_access && (haddr[7:0] == `ADDR_INTERRUPT_SRC);
   assign wr_mask   = wr_pend_q && (wr_addr_q == `ADDR_INTERRUPT_MASK);
   assign wr_fifo   = wr_pend_q && (wr_addr_q == `ADDR_FIFO_CONTROL);

   // remember the write address until its data phase
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= access && hwrite;
         if (access)
            wr_addr_q <= haddr[7:0];
      end
   end

   // ----------------------------------------
   // interrupt mask register
   // ----------------------------------------
   // power-down enable only exists on the full variant
   assign mask_keep = (HAS_POWER_DOWN != 0) ? `MASK_WRITABLE : `MASK_NO_PD;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interrupt_mask_q <= `MASK_RESET;
      end else if (wr_mask) begin
         interrupt_mask_q <= hwdata[7:0] & mask_keep;
      end
   end

   assign en_rx   = interrupt_mask_q[`MASK_RX_DATA];
   assign en_thre = interrupt_mask_q[`MASK_THR_EMPTY];
   assign en_ls   = interrupt_mask_q[`MASK_LINE_STATUS];
   assign en_ms   = interrupt_mask_q[`MASK_MODEM_STATUS];

   // both enables are needed before the clocks stop
   // on the variant without it, bit 5 never stores a one
   assign power_down = interrupt_mask_q[`MASK_POWER_DOWN] && modem_pd_bit;

   // ----------------------------------------
   // fifo control register
   // ----------------------------------------
   // clear bits are never stored, so each gives a one-cycle clear pulse
   // a write with bit 0 low only turns the fifos off
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fifo_en_q     <= 1'b0;
         dma_mode_q    <= 1'b0;
         trig_sel_q    <= `TRIG_SEL_1;
         rx_fifo_clear <= 1'b0;
         tx_fifo_clear <= 1'b0;
      end else begin
         rx_fifo_clear <= 1'b0;
         tx_fifo_clear <= 1'b0;
         if (wr_fifo) begin
            fifo_en_q <= hwdata[`FCR_FIFO_EN];
            if (hwdata[`FCR_FIFO_EN]) begin
               rx_fifo_clear <= hwdata[`FCR_RX_CLEAR];
               tx_fifo_clear <= hwdata[`FCR_TX_CLEAR];
               dma_mode_q    <= hwdata[`FCR_DMA_MODE];
               trig_sel_q    <= hwdata[`FCR_TRIG_HI:`FCR_TRIG_LO];
            end
         end
      end
   end

   assign fifo_enable = fifo_en_q;
   assign dma_mode    = dma_mode_q;

   // ----------------------------------------
   // trigger level and fill comparisons
   // ----------------------------------------
   // without fifos a single held character is the trigger
   // a new trigger applies from the cycle after the write lands
   always @* begin
      trig_level = `TRIG_LEVEL_1;
      if (fifo_en_q) begin
         if (trig_sel_q == `TRIG_SEL_1)
            trig_level = `TRIG_LEVEL_1;
         else if (trig_sel_q == `TRIG_SEL_4)
            trig_level = `TRIG_LEVEL_4;
         else if (trig_sel_q == `TRIG_SEL_8)
            trig_level = `TRIG_LEVEL_8;
         else
            trig_level = `TRIG_LEVEL_14;
      end
   end

   assign rx_empty   = (rx_count == `FIFO_EMPTY);
   assign tx_empty   = (tx_count == `FIFO_EMPTY);
   assign rx_at_trig = (rx_count >= trig_level);

   // mode 1 refills the tx fifo in blocks below the trigger
   assign thre_cond = (fifo_en_q && dma_mode_q) ? (tx_count < trig_level)
                                                : tx_empty;

   // ----------------------------------------
   // receive timeout
   // ----------------------------------------
   // armed only while data waits below the trigger
   // fifo clear restarts the wait, so no stale timeout survives
   rx_timeout u_rx_timeout (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .arm       (fifo_en_q && !rx_empty && !rx_at_trig),
      .restart   (rx_push || rx_pop || rx_fifo_clear),
      .char_tick (char_tick),
      .timeout_q (rx_timeout_q)
   );

   // ----------------------------------------
   // pending sources and priority
   // ----------------------------------------
   // rx data and timeout are levels: a source read cannot clear
   // them, only a change of fill or a push or pop does
   assign rx_data_int = en_rx && rx_at_trig;
   assign timeout_int = en_rx && fifo_en_q && rx_timeout_q;

   // highest enabled pending source wins the code
   always @* begin
      src_code = `SRC_NONE;
      if (en_ls && ls_pend_q)
         src_code = `SRC_LINE_STATUS;
      else if (rx_data_int)
         src_code = `SRC_RX_DATA;
      else if (timeout_int)
         src_code = `SRC_RX_TIMEOUT;
      else if (en_thre && thre_pend_q)
         src_code = `SRC_THR_EMPTY;
      else if (en_ms && ms_pend_q)
         src_code = `SRC_MODEM_STATUS;
   end

   // events are latched; a read clears only the one it reports,
   // and an event in the same cycle as the read wins over it
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ls_pend_q   <= 1'b0;
         thre_pend_q <= 1'b0;
         thre_cond_q <= 1'b0;
         ms_pend_q   <= 1'b0;
      end else begin
         thre_cond_q <= thre_cond;
         if (line_event)
            ls_pend_q <= 1'b1;
         else if (isr_read && src_code == `SRC_LINE_STATUS)
            ls_pend_q <= 1'b0;
         // the edge register resets low, so an idle tx side raises
         // one transmitter-empty event after reset
         if (thre_cond && !thre_cond_q)
            thre_pend_q <= 1'b1;
         else if (!thre_cond)
            thre_pend_q <= 1'b0;
         else if (isr_read && src_code == `SRC_THR_EMPTY)
            thre_pend_q <= 1'b0;
         if (modem_event)
            ms_pend_q <= 1'b1;
         else if (isr_read && src_code == `SRC_MODEM_STATUS)
            ms_pend_q <= 1'b0;
      end
   end

   // polled mode falls out of the enables: all clear means no line
   // no latch of its own: irq drops as soon as its source clears
   assign irq = (en_ls && ls_pend_q) || rx_data_int || timeout_int ||
                (en_thre && thre_pend_q) || (en_ms && ms_pend_q);

   // ----------------------------------------
   // line status flags
   // ----------------------------------------
   // level flags from fill counts, no latch to go stale
   // error bits pass through as the receiver reports them
   assign line_status_reg[0]   = !rx_empty;
   assign line_status_reg[4:1] = rx_error_bits;
   assign line_status_reg[5]   = tx_empty;
   assign line_status_reg[6]   = tx_empty && tx_shift_empty;
   assign line_status_reg[7]   = fifo_data_error;

   // ----------------------------------------
   // dma ready pins
   // ----------------------------------------
   // rx latch in mode 1 holds low until the fifo drains
   // without it a pop below the trigger would release the pin
   // while the dma engine is still draining the block
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_latch_q <= 1'b0;
      end else if (rx_empty) begin
         rx_latch_q <= 1'b0;
      end else if (rx_at_trig || rx_timeout_q) begin
         rx_latch_q <= 1'b1;
      end
   end

   // pins are registered so the dma side never sees glitches
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_ready_n_pin <= 1'b0;
         rx_ready_n_pin <= 1'b1;
      end else if (fifo_en_q && dma_mode_q) begin
         tx_ready_n_pin <= (tx_count == `FIFO_DEPTH);
         rx_ready_n_pin <= !(rx_latch_q || ((rx_at_trig || rx_timeout_q) && !rx_empty));
      end else begin
         tx_ready_n_pin <= !tx_empty;
         rx_ready_n_pin <= rx_empty;
      end
   end

   // ----------------------------------------
   // read data
   // ----------------------------------------
   // write-only fifo control shares its address with the source read
   // unmapped offsets read zero; writes to them fall away
   always @* begin
      rd_value = 8'h00;
      if (haddr[7:0] == `ADDR_INTERRUPT_MASK)
         rd_value = interrupt_mask_q;
      else if (haddr[7:0] == `ADDR_INTERRUPT_SRC)
         rd_value = {(fifo_en_q ? `SRC_FIFO_FLAGS : 2'h0), 2'h0, src_code};
      else if (haddr[7:0] == `ADDR_LINE_STATUS)
         rd_value = line_status_reg;
   end

   // captured at the address phase so side effects match the data
   // a read of the source register clears at that same edge
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (rd_access) begin
         hrdata <= {24'h000000, rd_value};
      end
   end

endmodule
`default_nettype wire

// *** sim/fifo_side_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------
// serial-side fifo fill model
// ------------------------------
module fifo_side_model (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       rx_fifo_clear,
   input  wire logic       tx_fifo_clear,
   input  wire logic [3:0] cmd,
   output logic      [4:0] rx_count,
   output logic      [4:0] tx_count,
   output logic            rx_push,
   output logic            rx_pop
);
   // a full rx fifo drops the character, as an overrun would
   assign rx_push = cmd[0] && rx_count != 5'h10;
   assign rx_pop  = cmd[1] && rx_count != 5'h00;
   // fill counters; clears win over traffic in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_count <= 5'h00;
         tx_count <= 5'h00;
      end else begin
         if (rx_fifo_clear)
            rx_count <= 5'h00;
         else
            rx_count <= rx_count + 5'(rx_push) - 5'(rx_pop);
         if (tx_fifo_clear)
            tx_count <= 5'h00;
         else if (cmd[2] && tx_count != 5'h10)
            tx_count <= tx_count + 5'h01;
         else if (cmd[3] && tx_count != 5'h00)
            tx_count <= tx_count - 5'h01;
      end
   end
endmodule
`default_nettype wire

// *** sim/uart_fifo_interrupt_control_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "uart_int_ctrl_defines.vh"
// ------------------------------
// self-checking bench
// ------------------------------
module uart_fifo_interrupt_control_bench;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [3:0]  rx_error_bits = 4'h0;
   logic        fifo_data_error = 1'b0;
   logic        modem_pd_bit = 1'b0;
   logic        tx_shift_empty = 1'b0;
   logic [6:0]  ev = 7'h00; // rx in, rx rd, tx wr, tx go, line, modem, tick
   logic [31:0] d;
   logic [31:0] srcs [3] = '{32'hC2, 32'hC0, 32'hC1};
   int          lvs [4] = '{1, 4, 8, 14};
   int          num_errors = 0;
   int          total_checks = 0;
   wire logic        hreadyout, hresp, irq, tx_ready_n_pin, rx_ready_n_pin, rx_push, rx_pop;
   wire logic        rx_fifo_clear, tx_fifo_clear, fifo_enable, dma_mode, power_down;
   wire logic [4:0]  rx_count, tx_count;
   wire logic [7:0]  line_status_reg;
   wire logic [31:0] hrdata;

   // free-running bus clock
   always #25 hclk = ~hclk;

   uart_int_ctrl dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rx_count, .tx_count, .rx_push,
      .rx_pop, .tx_shift_empty, .rx_error_bits, .fifo_data_error, .line_event(ev[4]),
      .modem_event(ev[5]), .modem_pd_bit, .char_tick(ev[6]), .irq, .tx_ready_n_pin,
      .rx_ready_n_pin, .rx_fifo_clear, .tx_fifo_clear, .fifo_enable, .dma_mode, .power_down,
      .line_status_reg);
   fifo_side_model far (.hclk, .hresetn, .rx_fifo_clear, .tx_fifo_clear, .cmd(ev[3:0]),
      .rx_count, .tx_count, .rx_push, .rx_pop);

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   // one single ahb transfer; read data lands in d
   task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge hclk);
      haddr <= {24'h000000, a};
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= v;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      d = hrdata;
   endtask
   // one-cycle strobes with a gap, so no strobe is set twice per step
   task pulse(input int b, input int n);
      @(posedge hclk);
      repeat (n) begin
         ev[b] <= 1'b1;
         @(posedge hclk);
         ev[b] <= 1'b0;
         @(posedge hclk);
      end
   endtask
   task stl;
      @(posedge hclk);
      #1;
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task t_reset;
      bus(1'b0, `ADDR_INTERRUPT_MASK, 32'h0);
      chk("mask", 32'h0, d);
      bus(1'b0, `ADDR_INTERRUPT_SRC, 32'h0);
      chk("source", 32'h01, d);
      chk("tx ready", 32'h0, 32'(tx_ready_n_pin));
      chk("rx ready", 32'h1, 32'(rx_ready_n_pin));
      $display("reset test done");
   endtask
   task t_mask;
      modem_pd_bit <= 1'b1;
      bus(1'b1, `ADDR_INTERRUPT_MASK, 32'hFF);
      bus(1'b0, `ADDR_INTERRUPT_MASK, 32'h0);
      chk("mask", 32'h2F, d);
      chk("power down", 32'h1, 32'(power_down));
      modem_pd_bit <= 1'b0;
      stl;
      chk("power down", 32'h0, 32'(power_down));
      bus(1'b1, `ADDR_INTERRUPT_MASK, 32'h0);
      $display("mask test done");
   endtask
   task t_fifo;
      pulse(0, 2);
      pulse(2, 2);
      bus(1'b1, `ADDR_FIFO_CONTROL, 32'h06); // clears without enable are ignored
      repeat (2) stl;
      chk("rx fill", 32'h2, 32'(rx_count));
      bus(1'b1, `ADDR_FIFO_CONTROL, 32'h03);
      repeat (2) stl;
      chk("rx fill", 32'h0, 32'(rx_count));
      chk("tx fill", 32'h2, 32'(tx_count));
      chk("fifo enable", 32'h1, 32'(fifo_enable));
      bus(1'b1, `ADDR_FIFO_CONTROL, 32'h05);
      repeat (2) stl;
      chk("tx fill", 32'h0, 32'(tx_count));
      $display("fifo control test done");
   endtask
   task t_trig;
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, `ADDR_FIFO_CONTROL, {24'h0, 2'(s), 6'h03});
         bus(1'b1, `ADDR_INTERRUPT_MASK, 32'h01);
         pulse(0, lvs[s] - 1);
         stl;
         chk("irq below", 32'h0, 32'(irq));
         pulse(0, 2);
         stl;
         chk("irq at", 32'h1, 32'(irq));
         bus(1'b0, `ADDR_INTERRUPT_SRC, 32'h0);
         chk("rx source", 32'hC4, d);
         pulse(1, 2);
         stl;
         chk("irq drop", 32'h0, 32'(irq));
      end
      $display("trigger test done");
   endtask
   task t_tmo;
      bus(1'b1, `ADDR_FIFO_CONTROL, 32'h4B); // trigger 4, dma mode 1
      pulse(0, 1);
      stl;
      chk("rx ready", 32'h1, 32'(rx_ready_n_pin));
      pulse(6, 4);
      repeat (2) stl;
      chk("rx ready", 32'h0, 32'(rx_ready_n_pin));
      bus(1'b0, `ADDR_INTERRUPT_SRC, 32'h0);
      chk("timeout source", 32'hCC, d);
      pulse(1, 1);
      repeat (2) stl;
      chk("rx ready", 32'h1, 32'(rx_ready_n_pin));
      chk("irq", 32'h0, 32'(irq));
      $display("timeout test done");
   endtask
   task t_prio;
      bus(1'b1, `ADDR_FIFO_CONTROL, 32'h07);
      pulse(2, 1);
      stl;
      chk("tx ready", 32'h1, 32'(tx_ready_n_pin));
      bus(1'b1, `ADDR_INTERRUPT_MASK, 32'h0F);
      rx_error_bits <= 4'hA;
      fifo_data_error <= 1'b1;
      pulse(3, 1);
      pulse(4, 1);
      pulse(5, 1);
      pulse(0, 1);
      stl;
      chk("irq", 32'h1, 32'(irq));
      bus(1'b0, `ADDR_INTERRUPT_SRC, 32'h0);
      chk("first", 32'hC6, d);
      bus(1'b0, `ADDR_INTERRUPT_SRC, 32'h0);
      chk("second", 32'hC4, d);
      bus(1'b0, `ADDR_LINE_STATUS, 32'h0);
      chk("line status", 32'hB5, d);
      tx_shift_empty <= 1'b1;
      stl;
      chk("line status", 32'hF5, 32'(line_status_reg));
      pulse(1, 1);
      for (int i = 0; i < 3; i++) begin
         bus(1'b0, `ADDR_INTERRUPT_SRC, 32'h0);
         chk("next", srcs[i], d);
      end
      chk("irq", 32'h0, 32'(irq));
      bus(1'b1, `ADDR_INTERRUPT_MASK, 32'h0);
      pulse(4, 1);
      stl;
      chk("polled irq", 32'h0, 32'(irq));
      $display("priority test done");
   endtask
   task t_dma1;
      bus(1'b1, `ADDR_FIFO_CONTROL, 32'h4F); // trigger 4, dma mode 1
      pulse(2, 16);
      stl;
      chk("tx ready", 32'h1, 32'(tx_ready_n_pin));
      chk("dma mode", 32'h1, 32'(dma_mode));
      bus(1'b1, `ADDR_INTERRUPT_MASK, 32'h02);
      pulse(3, 1);
      stl;
      chk("tx ready", 32'h0, 32'(tx_ready_n_pin));
      chk("tx irq", 32'h0, 32'(irq));
      pulse(3, 12); // fill 3: below trigger, not yet empty
      stl;
      chk("tx irq", 32'h1, 32'(irq));
      $display("dma mode 1 test done");
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset;
      t_mask;
      t_fifo;
      t_trig;
      t_tmo;
      t_prio;
      t_dma1;
      print_verdict;
   end
   // watchdog: the whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge hclk);
      num_errors++;
      $display("watchdog expired");
      print_verdict;
   end
endmodule
`default_nettype wire

// *** sim/uart_int_ctrl_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "uart_int_ctrl_defines.vh"
// ------------------------------
// port-level checker
// ------------------------------
module uart_int_ctrl_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic [4:0]  rx_count,
   input wire logic [4:0]  tx_count,
   input wire logic        tx_shift_empty,
   input wire logic [3:0]  rx_error_bits,
   input wire logic        fifo_data_error,
   input wire logic        modem_pd_bit,
   input wire logic        irq,
   input wire logic        tx_ready_n_pin,
   input wire logic        rx_ready_n_pin,
   input wire logic        rx_fifo_clear,
   input wire logic        fifo_enable,
   input wire logic        dma_mode,
   input wire logic        power_down,
   input wire logic [7:0]  line_status_reg
);
   // mode decode; fifos off behaves as dma mode 0
   wire logic m0 = !fifo_enable || !dma_mode;
   wire logic m1 = fifo_enable && dma_mode;
   wire logic take = hsel && htrans[1] && hready;
   wire logic rd_src = take && !hwrite && haddr[7:0] == `ADDR_INTERRUPT_SRC;
   wire logic wr_fcr = take && hwrite && haddr[7:0] == `ADDR_FIFO_CONTROL;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_rx0; m0 |=> rx_ready_n_pin == ($past(rx_count) == 5'h00); endproperty
   a_rx0: assert property (p_rx0)
      else $error("rx ready pin wrong in mode 0");
   property p_tx0; m0 |=> tx_ready_n_pin == ($past(tx_count) != 5'h00); endproperty
   a_tx0: assert property (p_tx0)
      else $error("tx ready pin wrong in mode 0");
   property p_tx1; m1 |=> tx_ready_n_pin == ($past(tx_count) == `FIFO_DEPTH); endproperty
   a_tx1: assert property (p_tx1)
      else $error("tx ready pin wrong in mode 1");
   // the mode 1 latch lets go one cycle after the fifo empties
   property p_rx1;
      m1 && rx_count == 5'h00 && $past(rx_count) == 5'h00 |=> rx_ready_n_pin;
   endproperty
   a_rx1: assert property (p_rx1)
      else $error("rx ready pin low with empty fifo");
   property p_lsr;
      line_status_reg == {fifo_data_error, tx_count == 5'h00 && tx_shift_empty,
                          tx_count == 5'h00, rx_error_bits, rx_count != 5'h00};
   endproperty
   a_lsr: assert property (p_lsr)
      else $error("line status flags wrong");
   property p_pd; power_down |-> modem_pd_bit; endproperty
   a_pd: assert property (p_pd)
      else $error("power down without modem control bit");
   // a clear pulse needs a write with enable and clear bits both set
   property p_clr;
      rx_fifo_clear |-> $past(wr_fcr, 2) && $past(hwdata[1:0]) == 2'h3 && !$past(rx_fifo_clear);
   endproperty
   a_clr: assert property (p_clr)
      else $error("rx clear pulse without cause");
   property p_src;
      rd_src |=> hrdata[7:4] == {{2{$past(fifo_enable)}}, 2'h0}
                 && (!hrdata[0] || hrdata[3:1] == 3'h0);
   endproperty
   a_src: assert property (p_src)
      else $error("interrupt source fields wrong");

   c_full: cover property (m1 && tx_count == `FIFO_DEPTH);
   c_clr: cover property (rx_fifo_clear);
   c_irq: cover property ($rose(irq));
endmodule

bind uart_int_ctrl uart_int_ctrl_chk chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
   .hwdata, .hready, .hrdata, .rx_count, .tx_count, .tx_shift_empty, .rx_error_bits,
   .fifo_data_error, .modem_pd_bit, .irq, .tx_ready_n_pin, .rx_ready_n_pin, .rx_fifo_clear,
   .fifo_enable, .dma_mode, .power_down, .line_status_reg);
`default_nettype wire
